// file: tb/iesw_bus_peer.sv
// Behavioural bus master that clocks bytes onto the open-drain bus.
`default_nettype none
module iesw_bus_peer (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output var  logic scl_rel_o,
   output var  logic sda_rel_o,
   output var  int   fall_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl_rel_o = 1'b1;
      sda_rel_o = 1'b1;
      fall_n_o = 0;
   end
   task automatic rise();
      scl_rel_o = 1'b1;
      wait (scl_i === 1'b1);
      #80;
   endtask
   task automatic start();
      sda_rel_o = 1'b1;
      #40;
      rise();
      sda_rel_o = 1'b0;
      #80;
      scl_rel_o = 1'b0;
      fall_n_o = 0;
      #40;
   endtask
   // Byte-end low phases are lengthened by the master so a late stretch still lands.
   task automatic put_byte(input logic [7:0] b, input logic ackd, output logic ack);
      for (int i = 0; i < 9; i++) begin
         sda_rel_o = (i < 8) ? b[7-i] : !ackd;
         #40;
         rise();
         ack = !sda_i;
         scl_rel_o = 1'b0;
         fall_n_o = i + 1;
         #(i >= 7 ? 340 : 40);
      end
   endtask
   task automatic stop();
      sda_rel_o = 1'b0;
      #40;
      rise();
      sda_rel_o = 1'b1;
      #400;
   endtask
endmodule // iesw_bus_peer
`default_nettype wire

// file: tb/iesw_core_sva.sv
// Port assertions for the bus event and wait core.
`default_nettype none
module iesw_core_sva (
   input wire logic       sys_clk_i,
   input wire logic       reset_n_i,
   input wire logic       scl_i,
   input wire logic       stop_irq_enable_i,
   input wire logic       wait_release_bit_i,
   input wire logic       serial_shift_write_i,
   input wire logic       start_request_i,
   input wire logic       stop_request_i,
   input wire logic       bus_event_irq_o,
   input wire logic       scl_oe_o,
   input wire logic [7:0] bus_status_byte_o
);
   timeunit 1ns;
   timeprecision 100ps;
   wire logic rel = wait_release_bit_i | serial_shift_write_i | start_request_i | stop_request_i;
   wire logic stp = bus_event_irq_o & bus_status_byte_o[0];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   irq_pulse_a: assert property (bus_event_irq_o |=> !bus_event_irq_o)
      else $error("Event pulse too long.");
   wait_start_a: assert property ($rose(scl_oe_o) |-> bus_event_irq_o)
      else $error("Wait began without an event.");
   scl_low_a: assert property (bus_event_irq_o && !stp |-> !scl_i)
      else $error("Event while the clock is high.");
   wait_end_a: assert property (scl_oe_o && rel |-> ##[1:3] !scl_oe_o)
      else $error("Wait not released.");
   wait_hold_a: assert property (scl_oe_o && !rel && !$past(rel) |=> scl_oe_o)
      else $error("Wait dropped on its own.");
   stop_mask_a: assert property (stp |-> stop_irq_enable_i)
      else $error("Stop event while disabled.");
   stop_nowait_a: assert property (stp |-> !scl_oe_o ##1 !scl_oe_o)
      else $error("Wait on a stop event.");
   status_hold_a: assert property (!bus_event_irq_o |-> $stable(bus_status_byte_o))
      else $error("Status changed without an event.");
endmodule // iesw_core_sva
bind iesw_core iesw_core_sva iesw_core_sva_inst (.sys_clk_i, .reset_n_i, .scl_i, .stop_irq_enable_i,
   .wait_release_bit_i, .serial_shift_write_i, .start_request_i, .stop_request_i, .bus_event_irq_o,
   .scl_oe_o, .bus_status_byte_o);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the bus event, status and wait core.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i, reset_n_i, wait_timing_select_i, stop_irq_enable_i, auto_ack_enable_i, wait_release_bit_i;
   logic serial_shift_write_i, start_request_i, stop_request_i, leave_bus_bit_i, master_active_i, master_tx_i;
   logic arb_lost_i, restart_low_i, status_read_i, status_ready_i, bus_event_irq_o, scl_oe_o, sda_oe_o;
   logic status_valid_o, scl_rel, sda_rel, ack;
   logic [6:0] own_address_reg_i;
   logic [7:0] bus_status_byte_o, ev_st;
   int fall_n, failures, checks, ev_n, ev_fall;
   wire logic scl_w = scl_rel & !scl_oe_o;
   wire logic sda_w = sda_rel & !sda_oe_o;
   iesw_core iesw_core_inst (.sys_clk_i, .reset_n_i, .scl_i(scl_w), .sda_i(sda_w), .own_address_reg_i,
      .wait_timing_select_i, .stop_irq_enable_i, .auto_ack_enable_i, .wait_release_bit_i, .serial_shift_write_i,
      .start_request_i, .stop_request_i, .leave_bus_bit_i, .master_active_i, .master_tx_i, .arb_lost_i,
      .restart_low_i, .status_read_i, .bus_event_irq_o, .scl_oe_o, .sda_oe_o, .bus_status_byte_o,
      .status_valid_o, .status_ready_i);
   iesw_bus_peer iesw_bus_peer_inst (.scl_i(scl_w), .sda_i(sda_w), .scl_rel_o(scl_rel), .sda_rel_o(sda_rel),
      .fall_n_o(fall_n));
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   task automatic sync();
      @(posedge sys_clk_i);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] care);
      checks++;
      if ((got & care) !== (exp & care)) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic byte_ev(input logic [7:0] b, input logic ackd, input int n, input int fall,
                          input logic [7:0] exp, input logic [7:0] care);
      int n0;
      sync();
      n0 = ev_n;
      iesw_bus_peer_inst.put_byte(b, ackd, ack);
      chk(8'(ev_n - n0), 8'(n), 8'hff);
      if (fall > 0) chk(8'(ev_fall), 8'(fall), 8'hff);
      if (n > 0) chk(ev_st, exp, care);
   endtask
   task automatic stop_ev(input logic en);
      int n0;
      sync();
      stop_irq_enable_i = en;
      n0 = ev_n;
      iesw_bus_peer_inst.stop();
      chk(8'(ev_n - n0), {7'h0, en}, 8'hff);
      if (en) chk(ev_st, 8'h01, 8'hff);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Software answers each event; the acknowledge choice is settled long before release, which
   // rotates through all four release kinds.
   // settle before release
   initial forever begin
      @(posedge sys_clk_i);
      if (bus_event_irq_o === 1'b1) begin
         ev_n++;
         ev_fall = fall_n;
         ev_st = bus_status_byte_o;
         repeat (3) sync();
         {wait_release_bit_i, serial_shift_write_i, start_request_i, stop_request_i} = 4'h8 >> (ev_n % 4);
         sync();
         {wait_release_bit_i, serial_shift_write_i, start_request_i, stop_request_i} = 4'h0;
      end
   end
   initial forever begin
      sync();
      status_ready_i = 1'($urandom);
   end
   initial begin
      #600us;
      failures++;
      tally_and_finish();
   end
   initial begin
      {reset_n_i, wait_timing_select_i, stop_irq_enable_i, auto_ack_enable_i, wait_release_bit_i} = 5'h0;
      {serial_shift_write_i, start_request_i, stop_request_i, leave_bus_bit_i, master_active_i} = 5'h0;
      {master_tx_i, arb_lost_i, restart_low_i, status_read_i, status_ready_i} = 5'h0;
      {failures, checks, ev_n, ev_fall} = '0;
      void'($urandom(69));
      own_address_reg_i = 7'h10 + 7'($urandom_range(95));
      auto_ack_enable_i = 1'($urandom);
      repeat (5) sync();
      reset_n_i = 1'b1;
      chk(bus_status_byte_o | {bus_event_irq_o, scl_oe_o, sda_oe_o, 5'h0}, 8'h00, 8'hff);
      for (int w = 0; w < 2; w++) begin
         wait_timing_select_i = w[0];
         iesw_bus_peer_inst.start();
         byte_ev({own_address_reg_i, 1'b0}, 0, 1, 9, 8'h16, 8'hf7);
         chk({7'h0, ack}, 8'h01, 8'hff);
         repeat (2) byte_ev(8'($urandom), 0, 1, 8 + w, 8'h10, 8'hf3);
         stop_ev(1);
      end
      wait_timing_select_i = 1'b0;
      iesw_bus_peer_inst.start();
      byte_ev(8'h00, 0, 1, 8, 8'h22, 8'hf7);
      leave_bus_bit_i = 1'b1;
      byte_ev(8'($urandom), 0, 0, 0, 0, 0);
      stop_ev(1);
      leave_bus_bit_i = 1'b0;
      wait_timing_select_i = 1'b1;
      iesw_bus_peer_inst.start();
      byte_ev(8'hf0, 0, 2, 9, {5'h04, auto_ack_enable_i, 2'h2}, 8'hf7);
      byte_ev(8'($urandom), 0, 1, 9, 8'h20, 8'hf3);
      iesw_bus_peer_inst.start();
      byte_ev({~own_address_reg_i, 1'b0}, 0, 1, 0, 8'h02, 8'hfb);
      byte_ev(8'($urandom), 0, 0, 0, 0, 0);
      stop_ev(0);
      iesw_bus_peer_inst.start();
      byte_ev({~own_address_reg_i, 1'b0}, 0, 0, 0, 0, 0);
      stop_ev(1);
      wait_timing_select_i = 1'b0;
      {master_active_i, master_tx_i} = 2'b11;
      iesw_bus_peer_inst.start();
      byte_ev({~own_address_reg_i, 1'b0}, 1, 1, 9, 8'h8e, 8'hff);
      sync();
      {arb_lost_i, master_active_i, master_tx_i} = 3'b100;
      sync();
      arb_lost_i = 1'b0;
      byte_ev(8'($urandom), 0, 1, 8, 8'h40, 8'hff);
      status_read_i = 1'b1;
      sync();
      status_read_i = 1'b0;
      stop_ev(1);
      // Arbitration lost after the start, before the address byte: own address keeps us as slave, another leaves us out.
      for (int k = 0; k < 2; k++) begin
         sync();
         {master_active_i, master_tx_i} = 2'b11;
         iesw_bus_peer_inst.start();
         sync();
         {arb_lost_i, master_active_i, master_tx_i} = 3'b100;
         sync();
         arb_lost_i = 1'b0;
         if (k == 0) byte_ev({own_address_reg_i, 1'b0}, 0, 1, 9, 8'h56, 8'hf7);
         else byte_ev({~own_address_reg_i, 1'b0}, 1, 1, 9, 8'h46, 8'hff);
         status_read_i = 1'b1;
         sync();
         status_read_i = 1'b0;
         byte_ev(8'($urandom), 0, 1 - k, 8 * (1 - k), 8'h10, 8'hf3);
         stop_ev(1);
      end
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire

// file: verilog/iesw_buf.v
// Two-entry valid/ready buffer carrying status bytes to software.
`default_nettype none
module iesw_buf #(
   parameter WIDTH = 8
) (
   input  wire             sys_clk_i,
   input  wire             reset_n_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output reg              out_valid_o,
   input  wire             out_ready_i,
   output reg  [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] skid_r;
   reg             skid_vld_r;
   assign in_ready_o = ~skid_vld_r;
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         out_valid_o <= 1'b0;
         skid_vld_r  <= 1'b0;
         out_data_o  <= {WIDTH{1'b0}};
         skid_r      <= {WIDTH{1'b0}};
      end else begin
         if (!out_valid_o || out_ready_i) begin
            if (skid_vld_r) begin
               out_data_o <= skid_r;
               out_valid_o <= 1'b1;
               skid_vld_r <= in_valid_i;
               skid_r <= in_data_i;
            end else begin
               out_valid_o <= in_valid_i;
               out_data_o <= in_data_i;
            end
         end else if (in_valid_i && !skid_vld_r) begin
            // Output stalled, so park the new word rather than lose it.
            skid_vld_r <= 1'b1;
            skid_r <= in_data_i;
         end
      end
   end
endmodule // iesw_buf
`default_nettype wire

// file: verilog/iesw_core.v
// Status, interrupt timing and clock-stretch control of the serial bus controller.
`include "iesw_defines.vh"
`default_nettype none
// Summary of operation
// - Data bytes interrupt at clock 8 or 9.
// - Master address byte interrupts at clock nine.
// - Slave address interrupts on own match, extended code or restart miss.
// - Matching address always acknowledged.
// - Extended code interrupts at clock eight.
// - Unmatched address gives no interrupt, no wait.
// - Interrupt and wait start on falling SCL.
// - Release, shift write, start or stop end wait.
// - Stop interrupts only when enabled, status 00000001.
// - Extended code slave status patterns.
// - Restart unmatched reports 00000x10, then silent.
// - Not participating: only optional stop interrupt.
// - Lost arbitration, own address: continue as slave.
// - Lost arbitration on extended code reports 0110x010.
// - Lost address arbitration unaddressed reports 01000110.
// - Lost data arbitration reports 10001110 then 0100x000.
// - Lost to restart: 1000x110 then address status.
// - Lost to stop reports 01000001 via stop interrupt.
// - Low data at restart/stop reports 1000xx00 then lost.
// - Stop instead of restart reports 01000001.
// - Extended flag bit 5, match flag bit 4.
// - Master bit 7, start bit 1, stop bit 0.
module iesw_core (
   input  wire       sys_clk_i,
   input  wire       reset_n_i,
   input  wire       scl_i,
   input  wire       sda_i,
   input  wire [6:0] own_address_reg_i,
   input  wire       wait_timing_select_i,
   input  wire       stop_irq_enable_i,
   input  wire       auto_ack_enable_i,
   input  wire       wait_release_bit_i,
   input  wire       serial_shift_write_i,
   input  wire       start_request_i,
   input  wire       stop_request_i,
   input  wire       leave_bus_bit_i,
   input  wire       master_active_i,
   input  wire       master_tx_i,
   input  wire       arb_lost_i,
   input  wire       restart_low_i,
   input  wire       status_read_i,
   output reg        bus_event_irq_o,
   output reg        scl_oe_o,
   output reg        sda_oe_o,
   output reg  [7:0] bus_status_byte_o,
   output reg        status_valid_o,
   input  wire       status_ready_i
);
   reg [2:0] scl_s_r;
   reg [2:0] sda_s_r;
   reg       scl_q_r;
   reg       sda_q_r;
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         // Reset to the idle-high bus level so that no false edge follows reset.
         scl_s_r <= 3'h7;
         sda_s_r <= 3'h7;
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_s_r <= {scl_s_r[1:0], scl_i};
         sda_s_r <= {sda_s_r[1:0], sda_i};
         // A level counts only when the second and third stages agree.
         if (scl_s_r[1] == scl_s_r[2])
            scl_q_r <= scl_s_r[2];
         if (sda_s_r[1] == sda_s_r[2])
            sda_q_r <= sda_s_r[2];
      end
   end
   reg  scl_d_r;
   reg  sda_d_r;
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_q_r;
         sda_d_r <= sda_q_r;
      end
   end
   wire scl_rise = scl_q_r & ~scl_d_r;
   // Falling SCL raises every event except the stop event, which stop detection raises.
   wire scl_fall = ~scl_q_r & scl_d_r;
   wire start_det = scl_q_r & scl_d_r & sda_d_r & ~sda_q_r;
   wire stop_det  = scl_q_r & scl_d_r & ~sda_d_r & sda_q_r;

   // Idle, address phase, a transfer we take part in, or sitting out until a restart or stop.
   localparam ST_IDLE = 2'h0;
   localparam ST_ADDR = 2'h1;
   localparam ST_DATA = 2'h2;
   localparam ST_OUT  = 2'h3;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg       ald_r;
   reg       exc_r;
   reg       coi_r;
   reg       msts_r;
   reg       trc_r;
   reg       ackd_r;
   reg       std_r;
   reg       spd_r;
   reg       wait_r;
   reg       ack_drv_r;
   reg       irq_pend_r;
   // Set when a restart cuts into a transfer that we took part in.
   reg       resume_r;
   wire      buf_in_ready;
   wire [7:0] status_now = {msts_r, ald_r, exc_r, coi_r, trc_r, ackd_r, std_r, spd_r};
   wire [3:0] data_clk = wait_timing_select_i ? `IESW_CLK_NINE : `IESW_CLK_EIGHT;
   wire       ext_code = (shift_r[7:4] == `IESW_EXT_LO) || (shift_r[7:4] == `IESW_EXT_HI);
   wire       addr_hit = (shift_r[7:1] == own_address_reg_i);
   wire       release_req = wait_release_bit_i | serial_shift_write_i | start_request_i | stop_request_i;
   // The address is neither ours nor an extended code.
   wire       addr_miss = !addr_hit && !ext_code;

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (start_det) state_nxt = ST_ADDR;
         ST_ADDR: if (scl_fall && bit_cnt_r == `IESW_CLK_NINE)
                     state_nxt = (addr_hit || ext_code || (msts_r && !ald_r)) ? ST_DATA : ST_OUT;
         ST_DATA: if (leave_bus_bit_i) state_nxt = ST_OUT;
         ST_OUT:  state_nxt = ST_OUT;
         default: state_nxt = ST_IDLE;
      endcase
      if (stop_det)
         state_nxt = ST_IDLE;
      else if (start_det)
         state_nxt = ST_ADDR;
   end

   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         state_r    <= ST_IDLE;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         ald_r      <= 1'b0;
         exc_r      <= 1'b0;
         coi_r      <= 1'b0;
         msts_r     <= 1'b0;
         trc_r      <= 1'b0;
         ackd_r     <= 1'b0;
         std_r      <= 1'b0;
         spd_r      <= 1'b0;
         wait_r     <= 1'b0;
         ack_drv_r  <= 1'b0;
         irq_pend_r <= 1'b0;
         resume_r   <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         irq_pend_r <= 1'b0;
         if (start_det || stop_det)
            bit_cnt_r <= 4'h0;
         else if (scl_rise && state_r != ST_IDLE)
            bit_cnt_r <= (bit_cnt_r == `IESW_CLK_NINE) ? 4'h1 : bit_cnt_r + 4'h1;
         // Only the acknowledge clock stays out of the shifter, so every byte arrives whole.
         if (scl_rise && bit_cnt_r != `IESW_CLK_EIGHT)
            shift_r <= {shift_r[6:0], sda_q_r};
         if (scl_rise && bit_cnt_r == `IESW_CLK_EIGHT)
            ackd_r <= ~sda_q_r;
         if (scl_rise && bit_cnt_r == `IESW_CLK_NINE) begin
            std_r  <= 1'b0;
            ackd_r <= 1'b0;
         end
         if (arb_lost_i)
            ald_r <= 1'b1;
         else if (start_det || status_read_i)
            ald_r <= 1'b0;
         if (arb_lost_i)
            msts_r <= 1'b0;
         else if (start_det)
            msts_r <= master_active_i;
         trc_r <= master_tx_i;
         if (start_det) begin
            std_r <= 1'b1;
            spd_r <= 1'b0;
            exc_r <= 1'b0;
            coi_r <= 1'b0;
            ackd_r <= 1'b0;
            resume_r <= (state_r == ST_DATA);
         end else if (stop_det) begin
            std_r <= 1'b0;
            spd_r <= 1'b1;
            exc_r <= 1'b0;
            coi_r <= 1'b0;
            msts_r <= 1'b0;
            ackd_r <= 1'b0;
            ack_drv_r <= 1'b0;
            resume_r <= 1'b0;
            irq_pend_r <= stop_irq_enable_i;
         end
         if (state_r == ST_ADDR && scl_fall) begin
            if (bit_cnt_r == `IESW_CLK_EIGHT) begin
               exc_r <= ext_code;
               coi_r <= addr_hit;
               if (ext_code && !msts_r) begin
                  irq_pend_r <= 1'b1;
                  wait_r <= 1'b1;
               end
               ack_drv_r <= addr_hit | (ext_code & auto_ack_enable_i);
            end
            if (bit_cnt_r == `IESW_CLK_NINE) begin
               ack_drv_r <= 1'b0;
               // master address at nine; match; lost arbitration; restart miss and extended code below
               if ((msts_r && !ald_r) || addr_hit || ald_r) begin
                  irq_pend_r <= 1'b1;
                  wait_r <= 1'b1;
               end
               if (addr_miss && resume_r && !ald_r) begin
                  irq_pend_r <= 1'b1;
                  resume_r <= 1'b0;
               end
               if (ext_code && !msts_r && wait_timing_select_i)
                  irq_pend_r <= 1'b1;
            end
         end
         if (state_r == ST_DATA && scl_fall && bit_cnt_r == data_clk) begin
            irq_pend_r <= 1'b1;
            wait_r <= 1'b1;
         end
         if (state_r == ST_OUT && scl_fall && ald_r && bit_cnt_r == data_clk)
            irq_pend_r <= 1'b1;
         if (state_r == ST_DATA && scl_fall && restart_low_i && bit_cnt_r == `IESW_CLK_NINE)
            irq_pend_r <= 1'b1;
         if (release_req)
            wait_r <= 1'b0;
         if (stop_det || state_nxt == ST_OUT)
            wait_r <= 1'b0;
      end
   end

   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         bus_event_irq_o   <= 1'b0;
         scl_oe_o          <= 1'b0;
         sda_oe_o          <= 1'b0;
         bus_status_byte_o <= `IESW_STATUS_RST;
      end else begin
         bus_event_irq_o <= irq_pend_r & buf_in_ready;
         // A refused event must not leave a changed status byte behind it.
         if (irq_pend_r && buf_in_ready)
            bus_status_byte_o <= status_now;
         // The wait holds SCL low until software acts.
         scl_oe_o <= wait_r;
         sda_oe_o <= ack_drv_r;
      end
   end

   wire [7:0] buf_data;
   wire       buf_valid;
   iesw_buf #(
      .WIDTH (8)
   ) u_buf (
      .sys_clk_i   (sys_clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (irq_pend_r),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (status_now),
      .out_valid_o (buf_valid),
      .out_ready_i (status_ready_i),
      .out_data_o  (buf_data)
   );
   // Software-side valid flag, one cycle behind the buffer and low in the cycle after status_ready_i is high.
   always @(posedge sys_clk_i) begin
      if (!reset_n_i)
         status_valid_o <= 1'b0;
      else
         status_valid_o <= buf_valid & ~status_ready_i;
   end
   // software sets acknowledge first; leave bus handled above
endmodule // iesw_core
`default_nettype wire

// file: verilog/iesw_defines.vh
// Constants for the bus event, status and wait block.
`ifndef IESW_DEFINES_VH
`define IESW_DEFINES_VH
`define IESW_ST_MSTS      7
`define IESW_ST_ALD       6
`define IESW_ST_EXC       5
`define IESW_ST_COI       4
`define IESW_ST_TRC       3
`define IESW_ST_ACKD      2
`define IESW_ST_STD       1
`define IESW_ST_SPD       0
`define IESW_CLK_EIGHT    4'h8
`define IESW_CLK_NINE     4'h9
`define IESW_EXT_LO       4'h0
`define IESW_EXT_HI       4'hf
`define IESW_STATUS_RST   8'h00
`define IESW_BUF_DEPTH    2
`endif
